// *** bench/dac_output_sequencer_bench.sv ***
// Self-checking bench for the output sequencer.
// Assumes the checker is bound in and the pace pin comes from pace_source.
`timescale 1ns/1ns
module dac_output_sequencer_bench;
   import dac_seq_pkg::*;
   logic        core_clk, resetn, pace, trig, pace_run, up0, up1, irq; // Pins and flags
   bus_req_type bus;                 // Register request
   logic [15:0] rdata;               // Read data
   logic [11:0] code0, code1;        // Converter codes
   int          mismatches = 0;      // Failed comparisons
   int          check_count = 0;     // All comparisons
   int          upd_cnt = 0;         // Load pulses seen so far
   dac_output_sequencer u_dac_output_sequencer (
      .core_clk_i(core_clk), .resetn_i(resetn), .bus_i(bus), .rdata_o(rdata),
      .ext_output_pace_clock_i(pace), .ext_output_trigger_input_i(trig),
      .dac0_code_o(code0), .dac1_code_o(code1), .dac0_update_o(up0),
      .dac1_update_o(up1), .irq_o(irq));
   // 20-cycle period: half the dual limit, so half the edges must be ignored
   pace_source u_pace_source (.run_i(pace_run), .half_ns_i(16'h01f4), .pace_o(pace));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Counts loads so quiet spans can be checked
   always @(posedge core_clk) if (up0 || up1) upd_cnt <= upd_cnt + 1;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Strobe held high writes one sample per cycle
   task automatic fill(input int n);
      @(posedge core_clk);
      bus <= '{addr: REG_FIFOW, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
      tick(n);
      bus.wr <= 1'b0;
   endtask
   // Waits, bounded, for a load on one channel; n ends as gap minus one
   task automatic waitup(input logic ch, input logic [11:0] exp, input int lim, output int n);
      n = 0;
      #1;
      while ((ch ? up1 : up0) !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk({15'h0000, ch ? up1 : up0}, 16'h0001);
      chk({4'h0, ch ? code1 : code0}, {4'h0, exp});
      @(posedge core_clk);
   endtask
   task automatic test_reset;
      #1 chk({4'h0, code0}, {4'h0, CODE_MID});
      chk({4'h0, code1}, {4'h0, CODE_MID});
      rdchk(REG_CTRL, 16'h0000);
      rdchk(REG_DIV, DIV_RST);
      rdchk(REG_STAT, 16'h1000);
      rdchk(4'hf, 16'h0000);
      $display("test reset done");
   endtask
   task automatic test_single;
      wr(REG_DATA0, 16'h0fff);
      #1 chk({4'h0, code0}, 16'h0fff);
      wr(REG_DATA1, 16'h0000);
      #1 chk({4'h0, code1}, 16'h0000);
      chk({4'h0, code0}, 16'h0fff);
      $display("test single done");
   endtask
   task automatic test_stream;
      int u, g;
      wr(REG_CTRL, 16'h0001);
      wr(REG_DIV, 16'h0001); // Below the limit, so it is raised
      wr(REG_FIFOW, 16'h0111);
      wr(REG_FIFOW, 16'h0222);
      wr(REG_FIFOW, 16'h0333);
      u = upd_cnt;
      tick(60);
      chk(16'(upd_cnt), 16'(u));
      wr(REG_TRIG, 16'h0001);
      waitup(1'b0, 12'h111, 100, g);
      waitup(1'b0, 12'h222, 100, g);
      chk(16'(g), 16'h0013);
      waitup(1'b0, 12'h333, 100, g);
      tick(60);
      chk({15'h0000, irq}, 16'h0000);
      rdchk(REG_IRQS, 16'h0002);
      wr(REG_IRQM, 16'h0002);
      #1 chk({15'h0000, irq}, 16'h0001);
      wr(REG_STOP, 16'h0001);
      tick(4);
      wr(REG_IRQS, 16'h0002);
      rdchk(REG_IRQS, 16'h0000);
      wr(REG_IRQM, 16'h0000);
      $display("test stream done");
   endtask
   task automatic test_dual_ext;
      int u, g;
      wr(REG_CTRL, 16'h0075);
      wr(REG_FIFOW, 16'h00a1);
      wr(REG_FIFOW, 16'h00b2);
      wr(REG_FIFOW, 16'h00c3);
      wr(REG_FIFOW, 16'h00d4);
      pace_run <= 1'b1;
      @(posedge core_clk);
      trig <= 1'b1; // Wrong edge for a falling setup
      u = upd_cnt;
      tick(100);
      chk(16'(upd_cnt), 16'(u));
      trig <= 1'b0;
      waitup(1'b0, 12'h0a1, 200, g);
      waitup(1'b1, 12'h0b2, 200, g);
      waitup(1'b0, 12'h0c3, 200, g);
      waitup(1'b1, 12'h0d4, 200, g);
      pace_run <= 1'b0;
      wr(REG_STOP, 16'h0001);
      $display("test dual external done");
   endtask
   task automatic test_wave;
      int g;
      wr(REG_CTRL, 16'h0002);
      wr(REG_FIFOW, 16'h05a5);
      wr(REG_FIFOW, 16'h0a5a);
      wr(REG_TRIG, 16'h0001);
      waitup(1'b0, 12'h5a5, 100, g);
      waitup(1'b0, 12'ha5a, 100, g);
      waitup(1'b0, 12'h5a5, 100, g);
      waitup(1'b0, 12'ha5a, 100, g);
      wr(REG_STOP, 16'h0001);
      $display("test wave done");
   endtask
   task automatic test_fill;
      int g;
      wr(REG_CTRL, 16'h0001);
      wr(REG_IRQM, 16'h0001);
      fill(16384);
      tick(2);
      chk({15'h0000, irq}, 16'h0000);
      wr(REG_TRIG, 16'h0001);
      waitup(1'b0, 12'h000, 100, g);
      tick(2);
      chk({15'h0000, irq}, 16'h0001);
      wr(REG_STOP, 16'h0001);
      wr(REG_IRQS, 16'h0007);
      wr(REG_IRQM, 16'h0004);
      fill(32769);
      tick(2);
      chk({15'h0000, irq}, 16'h0001);
      rdchk(REG_IRQS, 16'h0004);
      $display("test fill done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Tests need about 50000 cycles; the watchdog allows 60000
   initial begin
      #3000000;
      mismatches++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      resetn = 1'b0;
      bus = '0;
      trig = 1'b0;
      pace_run = 1'b0;
      tick(12);
      resetn <= 1'b1;
      test_reset();
      test_single();
      test_stream();
      test_dual_ext();
      test_wave();
      test_fill();
      tally_and_finish();
   end
endmodule // dac_output_sequencer_bench

// *** bench/dac_seq_properties.sv ***
// Checker for the output sequencer; sees only the top-level ports.
// Assumes the register map and pulse timing set out in the package.
`timescale 1ns/1ns
module dac_seq_properties
   import dac_seq_pkg::*;
(
   input wire logic                     core_clk_i,    // Core clock
   input wire logic                     resetn_i,      // Sync reset, active low
   input wire dac_seq_pkg::bus_req_type bus_i,         // Register request
   input wire logic [15:0]              rdata_o,       // Read data
   input wire logic [11:0]              dac0_code_o,   // Channel 0 code
   input wire logic [11:0]              dac1_code_o,   // Channel 1 code
   input wire logic                     dac0_update_o, // Channel 0 load pulse
   input wire logic                     dac1_update_o, // Channel 1 load pulse
   input wire logic                     irq_o          // Interrupt level
);
   logic [6:0] ctrl_q; // Shadow of the control word
   logic [2:0] mask_q; // Shadow of the event mask
   logic [7:0] gap_q;  // Cycles since any load, saturating
   logic [7:0] gap0_q; // Cycles since a channel 0 load
   ctrl_type   c;      // Decoded shadow
   assign c = ctrl_type'(ctrl_q);
   // Shadows follow writes; gaps saturate so long idles never look fast
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ctrl_q <= 7'h00;
         mask_q <= 3'h0;
         gap_q  <= 8'hff;
         gap0_q <= 8'hff;
      end else begin
         if (bus_i.wr && bus_i.addr == REG_CTRL) ctrl_q <= bus_i.wdata[6:0];
         if (bus_i.wr && bus_i.addr == REG_IRQM) mask_q <= bus_i.wdata[2:0];
         gap_q  <= (dac0_update_o || dac1_update_o) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
         gap0_q <= dac0_update_o ? 8'h00 : gap0_q + {7'h00, gap0_q != 8'hff};
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_stop;
      bus_i.wr && bus_i.addr == REG_STOP;
   endsequence
   sequence s_quiet;
      ((c.mode0 == MODE_SINGLE || !dac0_update_o)
       && (c.mode1 == MODE_SINGLE || !dac1_update_o)) [*8];
   endsequence
   property p_wr0;
      bus_i.wr && bus_i.addr == REG_DATA0 && c.mode0 == MODE_SINGLE
         |=> dac0_update_o && dac0_code_o == $past(bus_i.wdata[11:0]);
   endproperty
   a_wr0: assert property (p_wr0) else $error("channel 0 write not applied");
   property p_wr1;
      bus_i.wr && bus_i.addr == REG_DATA1 && c.mode1 == MODE_SINGLE
         |=> dac1_update_o && dac1_code_o == $past(bus_i.wdata[11:0]);
   endproperty
   a_wr1: assert property (p_wr1) else $error("channel 1 write not applied");
   property p_rst;
      $rose(resetn_i) |-> dac0_code_o == CODE_MID && dac1_code_o == CODE_MID && !irq_o;
   endproperty
   a_rst: assert property (p_rst) else $error("codes not at midscale after reset");
   property p_nb;
      c.mode0 != MODE_SINGLE && c.mode1 != MODE_SINGLE |-> !(dac0_update_o && dac1_update_o);
   endproperty
   a_nb: assert property (p_nb) else $error("both channels loaded at once");
   property p_dual;
      (dac0_update_o || dac1_update_o) && c.mode0 == MODE_CONT && c.mode1 == MODE_CONT
         |-> gap_q >= 8'h27;
   endproperty
   a_dual: assert property (p_dual) else $error("dual stream too fast");
   property p_one;
      dac0_update_o && c.mode0 == MODE_CONT && c.mode1 != MODE_CONT |-> gap0_q >= 8'h13;
   endproperty
   a_one: assert property (p_one) else $error("single stream too fast");
   property p_irq;
      mask_q == 3'h0 |-> !irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt high while masked");
   property p_stop;
      s_stop |-> ##2 s_quiet;
   endproperty
   a_stop: assert property (p_stop) else $error("loads continue after stop");
   property p_rdc;
      bus_i.rd && bus_i.addr == REG_CTRL |=> rdata_o == {9'h000, $past(ctrl_q)};
   endproperty
   a_rdc: assert property (p_rdc) else $error("control read back wrong");
endmodule // dac_seq_properties
bind dac_output_sequencer dac_seq_properties u_dac_seq_properties (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .dac0_code_o(dac0_code_o), .dac1_code_o(dac1_code_o), .dac0_update_o(dac0_update_o),
   .dac1_update_o(dac1_update_o), .irq_o(irq_o));

// *** bench/pace_source.sv ***
// Partner model: the external pacing clock source on the pace pin.
// Assumes the bench enables it only for externally paced runs.
`timescale 1ns/1ns
module pace_source (
   input  wire logic        run_i,     // Clock runs only while high
   input  wire logic [15:0] half_ns_i, // Half period in ns
   output logic             pace_o     // Pacing clock pin
);
   // Stands still low between runs, but a period begun before run_i falls still runs to its end
   initial begin
      pace_o = 1'b0;
      forever begin
         wait (run_i);
         // Offset keeps pin edges clear of the core clock's edges
         #13;
         while (run_i) begin
            #(half_ns_i) pace_o = 1'b1;
            #(half_ns_i) pace_o = 1'b0;
         end
      end
   end
endmodule // pace_source

// *** hdl/dac_output_sequencer.sv ***
// Two-channel analog output sequencer: single value updates plus
// triggered, paced streaming from an on-board sample store.
// Assumes one 20 MHz clock, synchronous active-low reset, and external
// pins (pacing clock, trigger) that are asynchronous to the core clock.
//
// Overview of operation
// - Two channels, each with 12-bit output code
// - Single mode: data write updates output immediately
// - Software selects internal or external pacing clock
// - One streaming channel reaches 1 MS/s
// - Two streaming channels limited to 500 kS/s
// - Host fills 32K store; converters fed from it
// - Start after trigger, one sample per pace
// - Interrupt when fill drops below 16K
// - Repeat until data ends or software stops
// - Dual streaming: even to ch0, odd ch1
// - Waveform mode repeats loaded pattern after trigger
// - 16-bit counter on 10 MHz, rising edge paces
// - Internal rate from 152.6 S/s to 1 MS/s
// - External pace: update on its rising edge
// - Soft or external trigger, selectable edge
// - Soft flag write makes the trigger edge
// - External trigger input edge detected as trigger
// - Straight binary codes, 800h is bipolar zero
`timescale 1ns/1ns
module dac_output_sequencer
   import dac_seq_pkg::*;
(
   input  wire logic                      core_clk_i,                 // 20 MHz core clock
   input  wire logic                      resetn_i,                   // Sync reset, active low
   input  wire dac_seq_pkg::bus_req_type  bus_i,                      // Register request
   output logic [15:0]                    rdata_o,                    // Read data, next cycle
   input  wire logic                      ext_output_pace_clock_i,    // Pacing clock pin
   input  wire logic                      ext_output_trigger_input_i, // Trigger pin
   output logic [11:0]                    dac0_code_o,                // Channel 0 code
   output logic [11:0]                    dac1_code_o,                // Channel 1 code
   output logic                           dac0_update_o,              // Channel 0 load pulse
   output logic                           dac1_update_o,              // Channel 1 load pulse
   output logic                           irq_o                       // Level interrupt
);
   import dac_seq_pkg::*;

   // Sample store; one word per sample
   logic [11:0]        mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wptr_q, wptr_d;          // Write pointer
   logic [FIFO_AW-1:0] rptr_q, rptr_d;          // Read pointer
   logic [FIFO_AW-1:0] wstart_q, wstart_d;      // Pattern start in waveform mode
   logic [15:0]        count_q, count_d;        // Unread samples
   logic [15:0]        plen_q, plen_d;          // Pattern length

   // Registers
   ctrl_type           ctrl_q, ctrl_d;          // Control
   logic [15:0]        div_q, div_d;            // Pacing divisor
   logic [11:0]        code0_q, code0_d;        // Channel 0 code
   logic [11:0]        code1_q, code1_d;        // Channel 1 code
   logic               upd0_q, upd0_d;          // Channel 0 load pulse
   logic               upd1_q, upd1_d;          // Channel 1 load pulse
   logic               flag_q, flag_d;          // Soft trigger flag level
   logic [2:0]         irqs_q, irqs_d;          // Sticky events
   logic [2:0]         irqm_q, irqm_d;          // Mask
   logic [15:0]        rdata_q, rdata_d;        // Read data
   logic               phase_q, phase_d;        // Next sample goes to channel 1

   // Pin synchronisers and edge history
   logic [1:0]         pace_sync_q;             // Pace clock, two stages
   logic [1:0]         trig_sync_q;             // Trigger, two stages
   logic               pace_last_q;             // Pace level one cycle ago
   logic               trig_last_q;             // Trigger level one cycle ago

   // Pacing counter
   logic [7:0]         tb_cnt_q, tb_cnt_d;      // Core cycles counted up within one time base tick
   logic [15:0]        pcnt_q, pcnt_d;          // Divide-down counter
   logic [7:0]         gap_q, gap_d;            // Cycles since last external update

   // Sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} seq_state_type;
   seq_state_type      state_q, state_d;

   logic wr, rd, any_stream, both_stream, wave, tick, pace, trig_ev, take;
   logic store_full, store_empty, push, half_cross;
   logic [15:0] div_eff, min_div;
   logic [7:0]  min_gap;
   logic [11:0] rd_word;

   // Strobe decode
   assign wr = bus_i.wr;
   assign rd = bus_i.rd;

   // Stream configuration
   always_comb begin
      any_stream  = (ctrl_q.mode0 != MODE_SINGLE) || (ctrl_q.mode1 != MODE_SINGLE);
      both_stream = (ctrl_q.mode0 != MODE_SINGLE) && (ctrl_q.mode1 != MODE_SINGLE);
      wave        = (ctrl_q.mode0 == MODE_WAVE) || (ctrl_q.mode1 == MODE_WAVE);
      min_div     = both_stream ? MIN_DIV_TWO : MIN_DIV_ONE;
      min_gap     = both_stream ? EXT_GAP_TWO : EXT_GAP_ONE;
      // A divisor below the limit is raised to it, so the rate never
      // exceeds 1 MS/s (or 500 kS/s over both channels); 65535 gives the floor
      div_eff     = (div_q < min_div) ? min_div : div_q;
   end

   // Synchronise the pins; only the second stage is read
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         pace_sync_q <= 2'h0;
         trig_sync_q <= 2'h0;
         pace_last_q <= 1'b0;
         trig_last_q <= 1'b0;
      end else begin
         pace_sync_q <= {pace_sync_q[0], ext_output_pace_clock_i};
         trig_sync_q <= {trig_sync_q[0], ext_output_trigger_input_i};
         pace_last_q <= pace_sync_q[1];
         trig_last_q <= trig_sync_q[1];
      end
   end

   // Internal pacing counter: time base ticks counted down by the divisor
   always_comb begin
      tick     = (tb_cnt_q == 8'(TB_DIV - 1));
      tb_cnt_d = tick ? 8'h0 : tb_cnt_q + 8'h1;
      pcnt_d   = pcnt_q;
      if (state_q != ST_RUN) begin
         pcnt_d = 16'h0;
      end else if (tick) begin
         // Counter output rises once per div_eff ticks
         pcnt_d = (pcnt_q >= div_eff - 16'h1) ? 16'h0 : pcnt_q + 16'h1;
      end
   end

   // Pace event selection and the spacing counter for external edges
   always_comb begin
      // Counter saturates so a long pause never wraps into a short one
      gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h1;
      if (ctrl_q.pace_ext) begin
         // Rising edge on the pin, spaced no closer than the rate limit;
         // gap_q lags the pace by one cycle, hence the limit minus one
         pace = pace_sync_q[1] && !pace_last_q
                && (gap_q >= min_gap - 8'h1);
      end else begin
         pace = tick && (pcnt_q >= div_eff - 16'h1);
      end
      if (pace && state_q == ST_RUN) begin
         gap_d = 8'h0;
      end
   end

   // Trigger: soft flag or pin, on the chosen edge
   always_comb begin
      if (ctrl_q.trig_ext) begin
         trig_ev = ctrl_q.edge_fall ? (trig_last_q && !trig_sync_q[1])
                                    : (!trig_last_q && trig_sync_q[1]);
      end else begin
         // Any write to the flag stands for the chosen edge; the flag's
         // level only records which edge that was
         trig_ev = wr && (bus_i.addr == REG_TRIG);
      end
   end

   // Store flags and the sample about to leave
   always_comb begin
      store_full  = (count_q == 16'(FIFO_DEPTH));
      store_empty = (count_q == 16'h0);
      push        = wr && (bus_i.addr == REG_FIFOW) && !store_full;
      take        = (state_q == ST_RUN) && pace && !store_empty;
      rd_word     = mem[rptr_q];
   end

   // Sample store write port
   // No reset on the array: words past the fill level are never read
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wptr_q] <= bus_i.wdata[11:0];
      end
   end

   // Sequencer and pointer next state
   always_comb begin
      state_d  = state_q;
      wptr_d   = wptr_q;
      rptr_d   = rptr_q;
      wstart_d = wstart_q;
      count_d  = count_q;
      plen_d   = plen_q;
      phase_d  = phase_q;
      code0_d  = code0_q;
      code1_d  = code1_q;
      upd0_d   = 1'b0;
      upd1_d   = 1'b0;
      if (push) begin
         wptr_d = wptr_q + FIFO_AW'(1);
         plen_d = (plen_q == 16'(FIFO_DEPTH)) ? plen_q : plen_q + 16'h1;
      end
      unique case (state_q)
         ST_IDLE: begin
            phase_d = 1'b0;
            if (any_stream) begin
               state_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            // Trigger edges that came before arming are not remembered
            if (!any_stream) begin
               state_d = ST_IDLE;
            end else if (trig_ev) begin
               state_d  = ST_RUN;
               wstart_d = rptr_q;
            end
         end
         ST_RUN: begin
            if (!any_stream) begin
               state_d = ST_IDLE;
            end
         end
      endcase
      if (take) begin
         // Interleave only when both channels stream
         if (both_stream ? phase_q : (ctrl_q.mode0 == MODE_SINGLE)) begin
            code1_d = rd_word;
            upd1_d  = 1'b1;
         end else begin
            code0_d = rd_word;
            upd0_d  = 1'b1;
         end
         phase_d = both_stream ? !phase_q : 1'b0;
         if (wave && (rptr_q + FIFO_AW'(1) == wstart_q + FIFO_AW'(plen_q))) begin
            rptr_d = wstart_q;
         end else begin
            rptr_d = rptr_q + FIFO_AW'(1);
         end
      end
      // Waveform mode keeps the pattern; streaming consumes it
      if (take && !wave) begin
         count_d = count_d - 16'h1;
      end
      if (push) begin
         count_d = count_d + 16'h1;
      end
      // Single value writes go straight to the outputs
      if (wr && bus_i.addr == REG_DATA0 && ctrl_q.mode0 == MODE_SINGLE) begin
         code0_d = bus_i.wdata[11:0];
         upd0_d  = 1'b1;
      end
      if (wr && bus_i.addr == REG_DATA1 && ctrl_q.mode1 == MODE_SINGLE) begin
         code1_d = bus_i.wdata[11:0];
         upd1_d  = 1'b1;
      end
      // Stop flushes the store and returns to idle
      if (wr && bus_i.addr == REG_STOP) begin
         state_d = ST_IDLE;
         rptr_d  = FIFO_AW'(0);
         wptr_d  = FIFO_AW'(0);
         count_d = 16'h0;
         plen_d  = 16'h0;
      end
   end

   // Interrupt events; a new event beats a same-cycle clear
   // Only the take that moves the level from 16K to one below counts,
   // so a level hovering at half raises one event, not a burst
   always_comb begin
      half_cross = take && !wave && (count_q == FIFO_HALF) && !push;
      irqs_d = irqs_q;
      irqm_d = irqm_q;
      if (wr && bus_i.addr == REG_IRQS) begin
         irqs_d = irqs_q & ~bus_i.wdata[2:0];
      end
      if (wr && bus_i.addr == REG_IRQM) begin
         irqm_d = bus_i.wdata[2:0];
      end
      if (half_cross) begin
         irqs_d[IRQ_HALF] = 1'b1;
      end
      if (state_q == ST_RUN && pace && store_empty) begin
         irqs_d[IRQ_EMPTY] = 1'b1;
      end
      if (wr && bus_i.addr == REG_FIFOW && store_full) begin
         irqs_d[IRQ_OVF] = 1'b1;
      end
   end

   // Control registers and read mux
   always_comb begin
      ctrl_d  = ctrl_q;
      div_d   = div_q;
      flag_d  = flag_q;
      rdata_d = 16'h0;
      if (wr && bus_i.addr == REG_CTRL) begin
         // Bits above the control layout are ignored
         ctrl_d = ctrl_type'(bus_i.wdata[6:0]);
      end
      if (wr && bus_i.addr == REG_DIV) begin
         div_d = bus_i.wdata;
      end
      if (wr && bus_i.addr == REG_TRIG) begin
         flag_d = !ctrl_q.edge_fall;
      end
      // Reads have no side effects, so software may poll freely
      if (rd) begin
         unique case (bus_i.addr)
            REG_DATA0: rdata_d = {4'h0, code0_q};
            REG_DATA1: rdata_d = {4'h0, code1_q};
            REG_CTRL:  rdata_d = {9'h000, ctrl_q};
            REG_DIV:   rdata_d = div_q;
            REG_TRIG:  rdata_d = {15'h0, flag_q};
            REG_STAT:  rdata_d = {state_q == ST_RUN, state_q == ST_ARMED,
                                  store_full, store_empty, 12'(count_q[15:4])};
            REG_IRQS:  rdata_d = {13'h0, irqs_q};
            REG_IRQM:  rdata_d = {13'h0, irqm_q};
            default:   rdata_d = 16'h0;
         endcase
      end
   end

   // Register everything
   // Codes come up at midscale, which is zero volts in bipolar ranges
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_q  <= ST_IDLE;
         wptr_q   <= '0;
         rptr_q   <= '0;
         wstart_q <= '0;
         count_q  <= 16'h0;
         plen_q   <= 16'h0;
         phase_q  <= 1'b0;
         code0_q  <= CODE_MID;
         code1_q  <= CODE_MID;
         upd0_q   <= 1'b0;
         upd1_q   <= 1'b0;
         ctrl_q   <= '0;
         div_q    <= DIV_RST;
         flag_q   <= 1'b0;
         irqs_q   <= IRQ_RST;
         irqm_q   <= IRQ_RST;
         rdata_q  <= 16'h0;
         tb_cnt_q <= 8'h0;
         pcnt_q   <= 16'h0;
         gap_q    <= 8'hff;
      end else begin
         state_q  <= state_d;
         wptr_q   <= wptr_d;
         rptr_q   <= rptr_d;
         wstart_q <= wstart_d;
         count_q  <= count_d;
         plen_q   <= plen_d;
         phase_q  <= phase_d;
         code0_q  <= code0_d;
         code1_q  <= code1_d;
         upd0_q   <= upd0_d;
         upd1_q   <= upd1_d;
         ctrl_q   <= ctrl_d;
         div_q    <= div_d;
         flag_q   <= flag_d;
         irqs_q   <= irqs_d;
         irqm_q   <= irqm_d;
         rdata_q  <= rdata_d;
         tb_cnt_q <= tb_cnt_d;
         pcnt_q   <= pcnt_d;
         gap_q    <= gap_d;
      end
   end

   // Outputs
   assign rdata_o       = rdata_q;
   assign dac0_code_o   = code0_q;
   assign dac1_code_o   = code1_q;
   assign dac0_update_o = upd0_q;
   assign dac1_update_o = upd1_q;
   assign irq_o         = |(irqs_q & irqm_q);
endmodule // dac_output_sequencer

// *** hdl/dac_seq_pkg.sv ***
// Package for the two-channel analog output sequencer.
// Assumes a 20 MHz core clock and a plain strobe register port.
package dac_seq_pkg;
   // Clock and pacing time base
   localparam int unsigned CORE_CLK_HZ   = 20000000;   // Core clock rate
   localparam int unsigned TIMEBASE_HZ   = 10000000;   // Pacing counter time base
   localparam int unsigned TB_DIV        = CORE_CLK_HZ / TIMEBASE_HZ; // Core cycles per tick
   localparam int unsigned MAX_RATE_SPS  = 1000000;    // Single channel top rate
   localparam int unsigned DUAL_RATE_SPS = 500000;     // Both channels together when both stream
   // Least divisor that keeps the update rate at or under the limit
   localparam logic [15:0] MIN_DIV_ONE   = 16'((TIMEBASE_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS);
   localparam logic [15:0] MIN_DIV_TWO   = 16'((TIMEBASE_HZ + DUAL_RATE_SPS - 1) / DUAL_RATE_SPS);
   // Least core cycles between two external paced updates
   localparam logic [7:0]  EXT_GAP_ONE   = 8'(CORE_CLK_HZ / MAX_RATE_SPS);
   localparam logic [7:0]  EXT_GAP_TWO   = 8'(CORE_CLK_HZ / DUAL_RATE_SPS);

   // Sample storage
   localparam int unsigned FIFO_DEPTH    = 32768;      // 32K samples
   localparam int unsigned FIFO_AW       = 15;         // Address width
   localparam logic [15:0] FIFO_HALF     = 16'h4000;   // 16K samples
   localparam logic [11:0] CODE_MID      = 12'h800;    // Zero volts in bipolar ranges

   // Register offsets
   localparam logic [3:0] REG_DATA0  = 4'h0;  // Channel 0 code, single value
   localparam logic [3:0] REG_DATA1  = 4'h1;  // Channel 1 code, single value
   localparam logic [3:0] REG_CTRL   = 4'h2;  // Mode and source control
   localparam logic [3:0] REG_DIV    = 4'h3;  // Pacing counter divisor
   localparam logic [3:0] REG_FIFOW  = 4'h4;  // Sample write port
   localparam logic [3:0] REG_TRIG   = 4'h5;  // Soft trigger flag
   localparam logic [3:0] REG_STAT   = 4'h6;  // Run state and fill level
   localparam logic [3:0] REG_IRQS   = 4'h7;  // Sticky events, write one to clear
   localparam logic [3:0] REG_IRQM   = 4'h8;  // Event mask
   localparam logic [3:0] REG_STOP   = 4'h9;  // Any write stops streaming

   // Reset values
   localparam logic [15:0] DIV_RST   = 16'h000a;  // 1 MS/s
   localparam logic [2:0]  IRQ_RST   = 3'h0;

   // Interrupt bits
   localparam int unsigned IRQ_HALF  = 0;  // Fill dropped below half
   localparam int unsigned IRQ_EMPTY = 1;  // Ran out of samples
   localparam int unsigned IRQ_OVF   = 2;  // Write to a full store dropped

   // Channel mode
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_CONT   = 2'h1,
      MODE_WAVE   = 2'h2
   } ch_mode_type;

   // Control register layout
   typedef struct packed {
      logic        edge_fall;   // 1: falling edge triggers
      logic        trig_ext;    // 1: external trigger input
      logic        pace_ext;    // 1: external pacing clock
      ch_mode_type mode1;       // Channel 1 mode
      ch_mode_type mode0;       // Channel 0 mode
   } ctrl_type;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;
endpackage
